// [rtl/alu_slice.sv]
// 16-bit cascadable alu slice datapath with register bus
//
// Function
// - bits 2..0 pick operand pair R,S; zero means all-zero operand.
// - bits 5..3 pick add, two subtracts, or, and, and-not, xor, xnor.
// - codes 0..3: load Q, nothing, regfile with A out, regfile with F out.
// - codes 4,5 shift F down into regfile; code 4 shifts Q down too.
// - codes 6,7 shift F up into regfile; code 6 shifts Q up too.
// - codes 4,5 drive both lsb shift pins, codes 6,7 both msb pins; all other pins stay undriven, acting as inputs.
// - two independent read addresses; equal addresses give the same word.
// - regfile writes shifter output at the B address when enabled.
// - regfile write enable is active for destination codes 2 through 7.
// - regfile input picks F, F up or F down; ends take shift pins.
// - A and B words held stable through the cycle for the alu.
// - A feeds R, S and result mux; B feeds only S.
// - Q input picks F, Q up or Q down, pins at the ends.
// - Q updates on the rising clock edge.
// - slices chain through shift pins and carry; outside joins the ends.
// - result lines driven only while active-low output enable is low.
// - carry in has no effect on logical results.
// - overflow is carry into msb xor carry out of msb.
// - zero flag is open drain, released high when F is all zero.
module alu_slice (
    input  wire logic                      clk_i,
    input  wire logic                      nrst_i,
    input  wire logic [11:0]               axi_awaddr_i,
    input  wire logic                      axi_awvalid_i,
    output logic                           axi_awready_o,
    input  wire logic [31:0]               axi_wdata_i,
    input  wire logic [3:0]                axi_wstrb_i,
    input  wire logic                      axi_wvalid_i,
    output logic                           axi_wready_o,
    output logic [1:0]                     axi_bresp_o,
    output logic                           axi_bvalid_o,
    input  wire logic                      axi_bready_i,
    input  wire logic [11:0]               axi_araddr_i,
    input  wire logic                      axi_arvalid_i,
    output logic                           axi_arready_o,
    output logic [31:0]                    axi_rdata_o,
    output logic [1:0]                     axi_rresp_o,
    output logic                           axi_rvalid_o,
    input  wire logic                      axi_rready_i,
    input  wire alu_slice_pkg::micro_word_t micro_instruction_bits_i,
    input  wire logic [3:0]                a_addr_i,
    input  wire logic [3:0]                b_addr_i,
    input  wire logic [15:0]               direct_data_i,
    input  wire logic                      carry_in_i,
    input  wire logic                      result_oe_n_i,
    output logic [15:0]                    result_out_o,
    output logic                           result_out_oe_o,
    input  wire logic                      regfile_lsb_shift_pin_i,
    output logic                           regfile_lsb_shift_pin_o,
    output logic                           regfile_lsb_shift_pin_oe_o,
    input  wire logic                      regfile_msb_shift_pin_i,
    output logic                           regfile_msb_shift_pin_o,
    output logic                           regfile_msb_shift_pin_oe_o,
    input  wire logic                      dest_q_load_only_lsb_shift_pin_i,
    output logic                           dest_q_load_only_lsb_shift_pin_o,
    output logic                           dest_q_load_only_lsb_shift_pin_oe_o,
    input  wire logic                      dest_q_load_only_msb_shift_pin_i,
    output logic                           dest_q_load_only_msb_shift_pin_o,
    output logic                           dest_q_load_only_msb_shift_pin_oe_o,
    output logic                           carry_out_o,
    output logic                           overflow_flag_o,
    input  wire logic                      zero_flag_i,
    output logic                           zero_flag_o,
    output logic                           zero_flag_oe_o,
    output logic                           sign_o
);

    function automatic logic dest_down(input logic [2:0] d);
        return (d == alu_slice_pkg::DEST_BOTH_SHIFT_DOWN) || (d == alu_slice_pkg::DEST_REGFILE_SHIFT_DOWN);
    endfunction

    function automatic logic dest_up(input logic [2:0] d);
        return (d == alu_slice_pkg::DEST_BOTH_SHIFT_UP) || (d == alu_slice_pkg::DEST_REGFILE_SHIFT_UP);
    endfunction

    // ****************************************************************
    // operand selection
    // ****************************************************************
    logic [2:0]  dest;
    logic [15:0] rf [16];
    logic [15:0] a_word;
    logic [15:0] b_word;
    logic [15:0] q;
    logic [15:0] r_op;
    logic [15:0] s_op;
    logic [15:0] f;

    assign dest = micro_instruction_bits_i.dest;

    // words held while the cycle settles; write lands only at the edge
    assign a_word = rf[a_addr_i];
    assign b_word = rf[b_addr_i];

    always_comb begin
        r_op = '0;
        s_op = '0;
        case (micro_instruction_bits_i.src)
            alu_slice_pkg::SRC_A_WITH_Q:         begin r_op = a_word;        s_op = q;      end
            alu_slice_pkg::SRC_A_WITH_B:         begin r_op = a_word;        s_op = b_word; end
            alu_slice_pkg::SRC_ZERO_WITH_Q:      begin r_op = '0;            s_op = q;      end
            alu_slice_pkg::SRC_ZERO_WITH_B:      begin r_op = '0;            s_op = b_word; end
            alu_slice_pkg::SRC_ZERO_WITH_A:      begin r_op = '0;            s_op = a_word; end
            alu_slice_pkg::SRC_DIRECT_WITH_A:    begin r_op = direct_data_i; s_op = a_word; end
            alu_slice_pkg::SRC_DIRECT_WITH_Q:    begin r_op = direct_data_i; s_op = q;      end
            default:                             begin r_op = direct_data_i; s_op = '0;     end
        endcase
    end

    alu_core u_alu (
        .r_i             (r_op),
        .s_i             (s_op),
        .func_i          (micro_instruction_bits_i.func),
        .carry_in_i      (carry_in_i),
        .f_o             (f),
        .carry_out_o     (carry_out_o),
        .overflow_flag_o (overflow_flag_o)
    );

    // ****************************************************************
    // register file and q register
    // ****************************************************************
    logic        rf_we;
    logic [15:0] next_rf_word;
    logic [15:0] next_q;

    always_comb begin
        rf_we = dest >= alu_slice_pkg::DEST_REGFILE_LOAD_OUT_A;
        if (dest_down(dest)) begin
            next_rf_word = {regfile_msb_shift_pin_i, f[15:1]};
        end else if (dest_up(dest)) begin
            next_rf_word = {f[14:0], regfile_lsb_shift_pin_i};
        end else begin
            next_rf_word = f;
        end
        case (dest)
            alu_slice_pkg::DEST_Q_LOAD_ONLY:     next_q = f;
            alu_slice_pkg::DEST_BOTH_SHIFT_DOWN: next_q = {dest_q_load_only_msb_shift_pin_i, q[15:1]};
            alu_slice_pkg::DEST_BOTH_SHIFT_UP:   next_q = {q[14:0], dest_q_load_only_lsb_shift_pin_i};
            default:                             next_q = q;
        endcase
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            for (int i = 0; i < alu_slice_pkg::DEPTH; i++) begin
                rf[i] <= '0;
            end
            q <= '0;
        end else begin
            if (rf_we) begin
                rf[b_addr_i] <= next_rf_word;
            end
            q <= next_q;
        end
    end

    // ****************************************************************
    // pins and flags
    // ****************************************************************
    logic ctrl_drive;

    // A word out only for code 2
    // output enable, also gated by software
    assign result_out_o    = (dest == alu_slice_pkg::DEST_REGFILE_LOAD_OUT_A) ? a_word : f;
    assign result_out_oe_o = !result_oe_n_i && ctrl_drive;

    // end bits leave on pins for the neighbour slice
    assign regfile_lsb_shift_pin_o    = f[0];
    assign regfile_lsb_shift_pin_oe_o = dest_down(dest);
    assign regfile_msb_shift_pin_o    = f[15];
    assign regfile_msb_shift_pin_oe_o = dest_up(dest);
    assign dest_q_load_only_lsb_shift_pin_o       = q[0];
    assign dest_q_load_only_lsb_shift_pin_oe_o    = dest_down(dest);
    assign dest_q_load_only_msb_shift_pin_o       = q[15];
    assign dest_q_load_only_msb_shift_pin_oe_o    = dest_up(dest);

    // open drain, pulls low on nonzero
    assign zero_flag_o    = 1'b0;
    assign zero_flag_oe_o = |f;
    assign sign_o         = f[15];

    // ****************************************************************
    // register bus slave
    // ****************************************************************
    logic        zero_sync1;
    logic        zero_sync2;
    logic        aw_held;
    logic [11:0] aw_addr;
    logic        w_held;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic [1:0]  bresp;
    logic        bvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        rvalid;
    logic        next_aw_held;
    logic [11:0] next_aw_addr;
    logic        next_w_held;
    logic [31:0] next_w_data;
    logic [3:0]  next_w_strb;
    logic [1:0]  next_bresp;
    logic        next_bvalid;
    logic [31:0] next_rdata;
    logic [1:0]  next_rresp;
    logic        next_rvalid;
    logic        next_ctrl_drive;
    logic        do_write;
    alu_slice_pkg::flags_t flags;

    assign flags = '{sign: f[15], wired_zero: zero_sync2, overflow: overflow_flag_o, carry: carry_out_o};

    assign axi_awready_o = !aw_held;
    assign axi_wready_o  = !w_held;
    assign axi_arready_o = !rvalid;
    assign axi_bvalid_o  = bvalid;
    assign axi_bresp_o   = bresp;
    assign axi_rvalid_o  = rvalid;
    assign axi_rresp_o   = rresp;
    assign axi_rdata_o   = rdata;

    always_comb begin
        next_aw_held    = aw_held;
        next_aw_addr    = aw_addr;
        next_w_held     = w_held;
        next_w_data     = w_data;
        next_w_strb     = w_strb;
        next_bresp      = bresp;
        next_bvalid     = bvalid && !axi_bready_i;
        next_rdata      = rdata;
        next_rresp      = rresp;
        next_rvalid     = rvalid && !axi_rready_i;
        next_ctrl_drive = ctrl_drive;
        do_write        = aw_held && w_held && (!bvalid || axi_bready_i);
        if (axi_awvalid_i && !aw_held) begin
            next_aw_held = 1'b1;
            next_aw_addr = axi_awaddr_i;
        end
        if (axi_wvalid_i && !w_held) begin
            next_w_held = 1'b1;
            next_w_data = axi_wdata_i;
            next_w_strb = axi_wstrb_i;
        end
        if (do_write) begin
            next_aw_held = 1'b0;
            next_w_held  = 1'b0;
            next_bvalid  = 1'b1;
            next_bresp   = alu_slice_pkg::RESP_OKAY;
            case ({aw_addr[11:2], 2'h0})
                alu_slice_pkg::OFS_CTRL: begin
                    if (w_strb[0]) begin
                        next_ctrl_drive = w_data[alu_slice_pkg::CTRL_DRIVE_BIT];
                    end
                end
                alu_slice_pkg::OFS_STATUS, alu_slice_pkg::OFS_DEST_Q_LOAD_ONLY: ;
                default: next_bresp = alu_slice_pkg::RESP_SLVERR;
            endcase
        end
        if (axi_arvalid_i && !rvalid) begin
            next_rvalid = 1'b1;
            next_rresp  = alu_slice_pkg::RESP_OKAY;
            case ({axi_araddr_i[11:2], 2'h0})
                alu_slice_pkg::OFS_CTRL:   next_rdata = {31'h00000000, ctrl_drive};
                alu_slice_pkg::OFS_STATUS: next_rdata = {28'h0000000, flags};
                alu_slice_pkg::OFS_DEST_Q_LOAD_ONLY:   next_rdata = {16'h0000, q};
                default: begin
                    next_rdata = '0;
                    next_rresp = alu_slice_pkg::RESP_SLVERR;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            zero_sync1 <= 1'b0;
            zero_sync2 <= 1'b0;
            aw_held    <= 1'b0;
            aw_addr    <= '0;
            w_held     <= 1'b0;
            w_data     <= '0;
            w_strb     <= '0;
            bresp      <= alu_slice_pkg::RESP_OKAY;
            bvalid     <= 1'b0;
            rdata      <= '0;
            rresp      <= alu_slice_pkg::RESP_OKAY;
            rvalid     <= 1'b0;
            ctrl_drive <= alu_slice_pkg::CTRL_DRIVE_RESET;
        end else begin
            zero_sync1 <= zero_flag_i;
            zero_sync2 <= zero_sync1;
            aw_held    <= next_aw_held;
            aw_addr    <= next_aw_addr;
            w_held     <= next_w_held;
            w_data     <= next_w_data;
            w_strb     <= next_w_strb;
            bresp      <= next_bresp;
            bvalid     <= next_bvalid;
            rdata      <= next_rdata;
            rresp      <= next_rresp;
            rvalid     <= next_rvalid;
            ctrl_drive <= next_ctrl_drive;
        end
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);

    sequence s_q_load_then_idle;
        dest == alu_slice_pkg::DEST_Q_LOAD_ONLY ##1 dest == alu_slice_pkg::DEST_NO_LOAD;
    endsequence

    a_q_load_f: assert property (dest == alu_slice_pkg::DEST_Q_LOAD_ONLY |=> q == $past(f))
        else $error("q did not take F");
    a_q_load_hold: assert property (s_q_load_then_idle |=> q == $past(f, 2))
        else $error("q lost loaded value");
    a_rf_write_f: assert property (dest == alu_slice_pkg::DEST_REGFILE_LOAD_OUT_F
        |=> rf[$past(b_addr_i)] == $past(f))
        else $error("regfile missed F write");
    a_rf_down: assert property (dest_down(dest)
        |=> rf[$past(b_addr_i)] == {$past(regfile_msb_shift_pin_i), $past(f[15:1])})
        else $error("regfile down shift wrong");
    a_rf_up: assert property (dest_up(dest)
        |=> rf[$past(b_addr_i)] == {$past(f[14:0]), $past(regfile_lsb_shift_pin_i)})
        else $error("regfile up shift wrong");
    a_q_shift_up: assert property (dest == alu_slice_pkg::DEST_BOTH_SHIFT_UP
        |=> q == {$past(q[14:0]), $past(dest_q_load_only_lsb_shift_pin_i)})
        else $error("q up shift wrong");
    a_rf_no_write: assert property (dest < alu_slice_pkg::DEST_REGFILE_LOAD_OUT_A && b_addr_i != a_addr_i
        |=> rf[$past(b_addr_i)] == $past(b_word))
        else $error("regfile written without enable");
    a_pins_idle: assert property (dest < alu_slice_pkg::DEST_BOTH_SHIFT_DOWN
        |-> !(regfile_lsb_shift_pin_oe_o || regfile_msb_shift_pin_oe_o
              || dest_q_load_only_lsb_shift_pin_oe_o || dest_q_load_only_msb_shift_pin_oe_o))
        else $error("idle shift pin driven");
    a_y_a_word: assert property (dest == alu_slice_pkg::DEST_REGFILE_LOAD_OUT_A |-> result_out_o == a_word)
        else $error("result not A word");
    a_y_hiz: assert property (result_oe_n_i |-> !result_out_oe_o)
        else $error("result driven while disabled");
    a_zero_flag: assert property ((f == 16'h0000) == !zero_flag_oe_o)
        else $error("zero flag wrong");
    a_same_addr: assert property (a_addr_i == b_addr_i |-> a_word == b_word)
        else $error("ports differ on equal address");
    a_bus_answer: assert property (do_write |=> axi_bvalid_o)
        else $error("write not answered");

endmodule // alu_slice

// [rtl/alu_slice_pkg.sv]
// shared constants and types for the 16-bit alu slice
package alu_slice_pkg;

    // ****************************************************************
    // datapath widths
    // ****************************************************************
    localparam int WORD_W  = 16;
    localparam int ADDR_W  = 4;
    localparam int DEPTH   = 16;
    localparam int FIELD_W = 3;

    // ****************************************************************
    // operand pair codes, instruction bits 2..0
    // ****************************************************************
    localparam logic [2:0] SRC_A_WITH_Q         = 3'h0;
    localparam logic [2:0] SRC_A_WITH_B         = 3'h1;
    localparam logic [2:0] SRC_ZERO_WITH_Q      = 3'h2;
    localparam logic [2:0] SRC_ZERO_WITH_B      = 3'h3;
    localparam logic [2:0] SRC_ZERO_WITH_A      = 3'h4;
    localparam logic [2:0] SRC_DIRECT_WITH_A    = 3'h5;
    localparam logic [2:0] SRC_DIRECT_WITH_Q    = 3'h6;
    localparam logic [2:0] SRC_DIRECT_WITH_ZERO = 3'h7;

    // ****************************************************************
    // alu function codes, instruction bits 5..3
    // ****************************************************************
    localparam logic [2:0] FN_R_PLUS_S    = 3'h0;
    localparam logic [2:0] FN_S_MINUS_R   = 3'h1;
    localparam logic [2:0] FN_R_MINUS_S   = 3'h2;
    localparam logic [2:0] FN_OR          = 3'h3;
    localparam logic [2:0] FN_AND         = 3'h4;
    localparam logic [2:0] FN_NOT_R_AND_S = 3'h5;
    localparam logic [2:0] FN_XOR         = 3'h6;
    localparam logic [2:0] FN_XNOR        = 3'h7;

    // ****************************************************************
    // destination codes, instruction bits 8..6
    // ****************************************************************
    localparam logic [2:0] DEST_Q_LOAD_ONLY         = 3'h0;
    localparam logic [2:0] DEST_NO_LOAD             = 3'h1;
    localparam logic [2:0] DEST_REGFILE_LOAD_OUT_A  = 3'h2;
    localparam logic [2:0] DEST_REGFILE_LOAD_OUT_F  = 3'h3;
    localparam logic [2:0] DEST_BOTH_SHIFT_DOWN     = 3'h4;
    localparam logic [2:0] DEST_REGFILE_SHIFT_DOWN  = 3'h5;
    localparam logic [2:0] DEST_BOTH_SHIFT_UP       = 3'h6;
    localparam logic [2:0] DEST_REGFILE_SHIFT_UP    = 3'h7;

    // ****************************************************************
    // register map and fields
    // ****************************************************************
    localparam int         AXI_ADDR_W        = 12;
    localparam logic [11:0] OFS_CTRL         = 12'h000;
    localparam logic [11:0] OFS_STATUS       = 12'h004;
    localparam logic [11:0] OFS_DEST_Q_LOAD_ONLY         = 12'h008;
    localparam int         CTRL_DRIVE_BIT    = 0;
    localparam logic       CTRL_DRIVE_RESET  = 1'b1;
    localparam logic [1:0] RESP_OKAY         = 2'h0;
    localparam logic [1:0] RESP_SLVERR       = 2'h2;

    typedef struct packed {
        logic [2:0] dest;
        logic [2:0] func;
        logic [2:0] src;
    } micro_word_t;

    // status word layout, bit 0 upward: carry, overflow, wired zero, sign
    typedef struct packed {
        logic sign;
        logic wired_zero;
        logic overflow;
        logic carry;
    } flags_t;

endpackage : alu_slice_pkg

// [rtl/alu_core.sv]
// eight-function alu with carry and overflow
module alu_core (
    input  wire logic [15:0] r_i,
    input  wire logic [15:0] s_i,
    input  wire logic [2:0]  func_i,
    input  wire logic        carry_in_i,
    output logic      [15:0] f_o,
    output logic             carry_out_o,
    output logic             overflow_flag_o
);

    logic [16:0] sum;
    logic [15:0] op_a;
    logic [15:0] op_b;
    logic        arith;

    always_comb begin
        op_a  = r_i;
        op_b  = s_i;
        arith = 1'b1;
        f_o   = '0;
        case (func_i)
            alu_slice_pkg::FN_R_PLUS_S: begin
                op_a = r_i;
                op_b = s_i;
            end
            alu_slice_pkg::FN_S_MINUS_R: begin
                op_a = s_i;
                op_b = ~r_i;
            end
            alu_slice_pkg::FN_R_MINUS_S: begin
                op_a = r_i;
                op_b = ~s_i;
            end
            default: begin
                arith = 1'b0;
            end
        endcase
        sum = {1'b0, op_a} + {1'b0, op_b} + {16'h0000, carry_in_i};
        case (func_i)
            alu_slice_pkg::FN_OR:          f_o = r_i | s_i;
            alu_slice_pkg::FN_AND:         f_o = r_i & s_i;
            alu_slice_pkg::FN_NOT_R_AND_S: f_o = ~r_i & s_i;
            alu_slice_pkg::FN_XOR:         f_o = r_i ^ s_i;
            alu_slice_pkg::FN_XNOR:        f_o = ~(r_i ^ s_i);
            default:                       f_o = sum[15:0];
        endcase
        carry_out_o     = arith & sum[16];
        // carry into msb xor carry out
        overflow_flag_o = arith & (sum[16] ^ (sum[15] ^ op_a[15] ^ op_b[15]));
    end

endmodule // alu_core

// [verif/micro_word_reg.sv]
// microinstruction register model that feeds the slice every cycle
module micro_word_reg (
    input  wire logic                       clk_i,
    input  wire logic                       nrst_i,
    input  wire alu_slice_pkg::micro_word_t next_word_i,
    input  wire logic [7:0]                 next_addr_i,
    input  wire logic [16:0]                next_data_i,
    output alu_slice_pkg::micro_word_t      word_o,
    output logic [7:0]                      addr_o,
    output logic [16:0]                     data_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************************************
    // pipeline register
    // ****************************************************************
    // fields change only at the edge, stable all cycle
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            word_o <= '0;
            addr_o <= 8'h00;
            data_o <= 17'h00000;
        end else begin
            word_o <= next_word_i;
            addr_o <= next_addr_i;
            data_o <= next_data_i;
        end
    end
endmodule // micro_word_reg

// [verif/alu_slice_test.sv]
// self-checking bench for the alu slice
module alu_slice_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 0, nrst_i = 0, axi_awvalid_i = 0, axi_wvalid_i = 0, axi_arvalid_i = 0, result_oe_n_i = 0;
    logic axi_bready_i = 1, axi_rready_i = 1, chk = 0, chk_d = 0, c;
    logic axi_awready_o, axi_wready_o, axi_bvalid_o, axi_arready_o, axi_rvalid_o, result_out_oe_o, carry_out_o;
    logic                       zero_flag_oe_o;
    logic [11:0]                axi_awaddr_i = 0, axi_araddr_i = 0;
    logic [31:0]                axi_wdata_i = 0, axi_rdata_o, r32;
    logic [1:0]                 axi_bresp_o, axi_rresp_o;
    logic [15:0]                result_out_o, va, vb, vq, vd;
    logic [3:0]                 pin_o, pin_oe, pin_i, pin_drv = 4'hA;
    logic [7:0]                 ab, nx_ab = 0;
    logic [16:0]                cd, f, nx_cd = 0;
    logic [33:0]                obs, exp_q[$];
    alu_slice_pkg::micro_word_t mw, nx_w = '0;
    int                         mismatches = 0, n_tests = 0;
    // ****************************************************************
    // harness
    // ****************************************************************
    // neighbour drives a shift pin only while the slice releases it
    assign pin_i = (pin_oe & pin_o) | (~pin_oe & pin_drv);
    micro_word_reg seq (.clk_i, .nrst_i, .next_word_i(nx_w), .next_addr_i(nx_ab), .next_data_i(nx_cd),
        .word_o(mw), .addr_o(ab), .data_o(cd));
    alu_slice DUT (.clk_i, .nrst_i, .axi_awaddr_i, .axi_awvalid_i, .axi_awready_o, .axi_wdata_i,
        .axi_wstrb_i(4'hF), .axi_wvalid_i, .axi_wready_o, .axi_bresp_o, .axi_bvalid_o, .axi_bready_i,
        .axi_araddr_i, .axi_arvalid_i, .axi_arready_o, .axi_rdata_o, .axi_rresp_o, .axi_rvalid_o, .axi_rready_i,
        .micro_instruction_bits_i(mw), .a_addr_i(ab[7:4]), .b_addr_i(ab[3:0]), .direct_data_i(cd[15:0]),
        .carry_in_i(cd[16]), .result_oe_n_i, .result_out_o, .result_out_oe_o,
        .regfile_lsb_shift_pin_i(pin_i[0]), .regfile_lsb_shift_pin_o(pin_o[0]), .regfile_lsb_shift_pin_oe_o(pin_oe[0]),
        .regfile_msb_shift_pin_i(pin_i[1]), .regfile_msb_shift_pin_o(pin_o[1]), .regfile_msb_shift_pin_oe_o(pin_oe[1]),
        .dest_q_load_only_lsb_shift_pin_i(pin_i[2]), .dest_q_load_only_lsb_shift_pin_o(pin_o[2]), .dest_q_load_only_lsb_shift_pin_oe_o(pin_oe[2]),
        .dest_q_load_only_msb_shift_pin_i(pin_i[3]), .dest_q_load_only_msb_shift_pin_o(pin_o[3]), .dest_q_load_only_msb_shift_pin_oe_o(pin_oe[3]),
        .carry_out_o, .overflow_flag_o(), .zero_flag_i(!zero_flag_oe_o), .zero_flag_o(), .zero_flag_oe_o, .sign_o());
    initial forever #5 clk_i = ~clk_i;
    always @(posedge clk_i) chk_d <= chk;
    always @(posedge clk_i) begin
        if (chk_d || (axi_rvalid_o && axi_rready_i)) begin
            obs = chk_d ? {16'h0, result_out_oe_o, carry_out_o, result_out_o} : {axi_rresp_o, axi_rdata_o};
            n_tests++;
            if (exp_q.size() == 0 || obs !== exp_q[0]) begin
                mismatches++;
                $display("CHECK FAILED %0t got %h", $time, obs);
            end
            if (exp_q.size() != 0) void'(exp_q.pop_front());
        end
    end
    function automatic logic [16:0] alu(input logic [8:0] i, input logic [15:0] a, b, q, d, input logic ci);
        logic [15:0] r, s;
        r = (i[2] && i[1:0] != 2'h0) ? d : (i[2:1] == 2'h0 ? a : 16'h0);
        s = i[2:0] inside {3'h0, 3'h2, 3'h6} ? q : i[2:0] inside {3'h1, 3'h3} ? b : i[2:0] == 3'h7 ? 16'h0 : a;
        case (i[5:3])
            3'h0: alu = {1'h0, r} + s + ci;
            3'h1: alu = {1'h0, s} + {1'h0, ~r} + ci;
            3'h2: alu = {1'h0, r} + {1'h0, ~s} + ci;
            3'h3: alu = {1'h0, r | s};
            3'h4: alu = {1'h0, r & s};
            3'h5: alu = {1'h0, ~r & s};
            3'h6: alu = {1'h0, r ^ s};
            default: alu = {1'h0, ~(r ^ s)};
        endcase
    endfunction
    task automatic results;
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // one microinstruction; the compare lands two edges later
    task automatic op(input logic [8:0] i, input logic [3:0] a, b, input logic [15:0] d, input logic ci,
                      input logic en, input logic [33:0] e);
        nx_w <= i;
        nx_ab <= {a, b};
        nx_cd <= {ci, d};
        chk <= en;
        if (en) exp_q.push_back(e);
        @(posedge clk_i);
    endtask
    task automatic tick(inout int n);
        @(posedge clk_i);
        n++;
        if (n > 50) begin
            mismatches++;
            results();
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        int n = 0;
        chk <= 1'h0;
        axi_awaddr_i <= a;
        axi_wdata_i <= d;
        axi_awvalid_i <= 1'h1;
        axi_wvalid_i <= 1'h1;
        do begin
            tick(n);
            if (axi_awready_o) axi_awvalid_i <= 1'h0;
            if (axi_wready_o) axi_wvalid_i <= 1'h0;
        end while (!axi_bvalid_o);
    endtask
    task automatic rd(input logic [11:0] a, input logic [33:0] e);
        int n = 0;
        exp_q.push_back(e);
        chk <= 1'h0;
        axi_araddr_i <= a;
        axi_arvalid_i <= 1'h1;
        do begin
            tick(n);
            if (axi_arready_o) axi_arvalid_i <= 1'h0;
        end while (!axi_rvalid_o);
    endtask
    initial begin
        r32 = $urandom(32'hE589);
        repeat (4) @(posedge clk_i);
        nrst_i <= 1'h1;
        @(posedge clk_i);
        {va, vb} = $urandom;
        {vq, vd} = $urandom;
        op(9'o307, 4'h0, 4'h1, va, 1'h0, 1'h0, 34'h0);
        op(9'o307, 4'h0, 4'h2, vb, 1'h0, 1'h0, 34'h0);
        op(9'o007, 4'h0, 4'h0, vq, 1'h0, 1'h0, 34'h0);
        for (int k = 0; k < 64; k++) begin
            r32 = $urandom;
            c = r32[0];
            f = alu({3'h1, k[5:0]}, va, vb, vq, vd, c);
            op({3'h1, k[5:0]}, 4'h1, 4'h2, vd, c, 1'h1, {16'h0, 1'h1, f});
        end
        op(9'o161, 4'h2, 4'h2, vd, 1'h1, 1'h1, {18'h2, 16'h0});
        op(9'o207, 4'h1, 4'h5, vd, 1'h0, 1'h1, {18'h2, va});
        op(9'o104, 4'h5, 4'h0, vd, 1'h0, 1'h1, {18'h2, vd});
        $display("alu and routing test done");
        for (int k = 4; k < 8; k += 2) begin
            op({k[2:0], 6'o07}, 4'h0, 4'h3, vd, 1'h0, 1'h0, 34'h0);
            op(9'o104, 4'h3, 4'h0, vd, 1'h0, 1'h1, {18'h2, k == 4 ? {1'h1, vd[15:1]} : {vd[14:0], 1'h0}});
            vq = (k == 4) ? {1'h1, vq[15:1]} : {vq[14:0], 1'h0};
            rd(alu_slice_pkg::OFS_DEST_Q_LOAD_ONLY, {18'h0, vq});
        end
        $display("shift test done");
        rd(alu_slice_pkg::OFS_CTRL, 34'h1);
        rd(12'hFF0, {alu_slice_pkg::RESP_SLVERR, 32'h0});
        wr(alu_slice_pkg::OFS_CTRL, 32'h0);
        op(9'o104, 4'h1, 4'h0, vd, 1'h0, 1'h1, {18'h0, va});
        wr(alu_slice_pkg::OFS_CTRL, 32'h1);
        result_oe_n_i <= 1'h1;
        op(9'o104, 4'h1, 4'h0, vd, 1'h0, 1'h1, {18'h0, va});
        op(9'o104, 4'h1, 4'h0, vd, 1'h0, 1'h1, {18'h2, va});
        result_oe_n_i <= 1'h0;
        chk <= 1'h0;
        repeat (3) @(posedge clk_i);
        $display("output enable test done");
        results();
    end
endmodule // alu_slice_test
